// *** pkg/gmp_pkg.sv ***
package gmp_pkg;
  // ----------------------------------------
  // timebase
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int SLEEP_QUALIFY_MS = 2000;
  localparam int SLEEP_QUALIFY_CYC = SLEEP_QUALIFY_MS * (CLK_HZ / 1000);
  localparam int VT_UPDATE_MS = 440;
  localparam int VT_UPDATE_CYC = VT_UPDATE_MS * (CLK_HZ / 1000);
  localparam int CUR_UPDATE_US = 3_515_000;
  localparam int CUR_UPDATE_CYC = CUR_UPDATE_US * (CLK_HZ / 1_000_000);
  localparam int SAMPLE_HZ = 18_600;
  localparam int SAMPLE_DIV_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int CNT_W = 32;

  // ----------------------------------------
  // data formats
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int WIDE_W = 52;
  localparam int SUM_W = 36;
  localparam int CONV_SHIFT = 16;
  localparam int AVG_DEPTH = 8;
  localparam int AVG_SHIFT = 3;
  localparam int OFS_IDX_W = 10;
  localparam int GAIN_W = 11;
  localparam int GAIN_FRAC = 10;
  localparam int TC_W = 8;
  localparam int TC_HALF_SHIFT = 2;
  localparam int TC_REF_HALF = 50;
  localparam int TC_ONE = 65536;
  localparam int TC_SHIFT = 16;
  localparam int VOLT_MAX = 1023;
  localparam int VOLT_MIN = -1024;
  localparam int CUR_MAX = 32767;
  localparam int CUR_MIN = -32768;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_VOLT = 4'h2;
  localparam logic [3:0] REG_TEMP = 4'h3;
  localparam logic [3:0] REG_CUR = 4'h4;
  localparam logic [3:0] REG_AVG = 4'h5;
  localparam logic [3:0] REG_GAIN = 4'h6;
  localparam logic [3:0] REG_FGAIN = 4'h7;
  localparam logic [3:0] REG_TC = 4'h8;
  localparam logic [3:0] REG_OFFSET = 4'h9;
  localparam int CTRL_BLS_BIT = 0;
  localparam int CTRL_UVS_BIT = 1;
  localparam int STAT_SLEEP_BIT = 0;
  localparam int STAT_UV_BIT = 1;
  localparam int STAT_OVD_BIT = 2;
  localparam int STAT_LOWQ_BIT = 3;
  localparam logic [10:0] GAIN_RESET = 11'h400;

  typedef enum logic [1:0] {
    GMP_ACTIVE = 2'b00,
    GMP_SLEEP_BUS = 2'b01,
    GMP_SLEEP_UV = 2'b10
  } gmp_pwr_e;

  typedef struct packed {
    logic bus_low_sleep_enable;
    logic undervoltage_sleep_enable;
  } gmp_ctrl_s;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } gmp_acc_s;
endpackage : gmp_pkg

// *** hdl/gmp_measure_power_ctrl.sv ***
// Notes on behaviour
// - power-up starts in active, measuring continuously
// - sleep halts measurement, registers keep values
// - bus-low enable plus line low 2s: sleep
// - bus-low sleep ends when line goes high
// - undervoltage plus steady line 2s: sleep
// - undervoltage sleep lasts until line activity
// - line-high undervoltage sleep accepts reset directly
// - no presence on first rise after low sleep
// - voltage refreshed every 440ms, 4.88mV step
// - voltage clamped to register range
// - temperature 0.125C step, refreshed every 440ms
// - sense sampled 18.6kHz, result per conversion
// - current written every 3.515s, 1.5625uV step
// - current saturates at 7fff and 8000
// - average of last 8 currents every 28s
// - every 1024th conversion measures offset
// - offset slot repeats previous current value
// - 11-bit gain trim, 0 to 1.999
// - factory gain copy read-only, unused
// - 8-bit tempco trim, zero disables
// - tempco factor recomputed on 0.5C crossing
// - speed select pin high means overdrive
`timescale 1ns/100ps
module gmp_measure_power_ctrl
  import gmp_pkg::*;
#(
  parameter int SLEEP_CYC = SLEEP_QUALIFY_CYC,
  parameter int VT_CYC = VT_UPDATE_CYC,
  parameter int CUR_CYC = CUR_UPDATE_CYC,
  parameter int SAMPLE_CYC = SAMPLE_DIV_CYC,
  parameter logic [10:0] FACTORY_GAIN = GAIN_RESET
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic dq_i,
  input wire logic bus_speed_select_i,
  input wire logic uv_below_i,
  input wire logic signed [15:0] vin_raw_i,
  input wire logic signed [10:0] temp_raw_i,
  input wire logic signed [15:0] sns_sample_i,
  output logic sample_tick_o,
  output logic sleep_o,
  output logic overdrive_o,
  output logic presence_block_o,
  output gmp_acc_s acc_feed_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic signed [15:0] sat16(
    input logic signed [WIDE_W-1:0] v,
    input int lo,
    input int hi
  );
    logic signed [WIDE_W-1:0] l;
    logic signed [WIDE_W-1:0] h;
    l = WIDE_W'(lo);
    h = WIDE_W'(hi);
    if (v > h) begin
      sat16 = h[15:0];
    end else if (v < l) begin
      sat16 = l[15:0];
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic tick(input logic [CNT_W-1:0] c, input int n);
    tick = (c == CNT_W'(n - 1));
  endfunction : tick

  // ----------------------------------------
  // state
  // ----------------------------------------
  gmp_pwr_e pwr_r, pwr_nxt;
  gmp_ctrl_s ctrl_r;
  logic dq_prev_r;
  logic low_at_sleep_r;
  logic presence_block_r;
  logic overdrive_r;
  logic [CNT_W-1:0] qual_cnt_r;
  logic [CNT_W-1:0] vt_cnt_r;
  logic [CNT_W-1:0] cur_cnt_r;
  logic [CNT_W-1:0] smp_cnt_r;
  logic signed [SUM_W-1:0] sum_r;
  logic [OFS_IDX_W-1:0] conv_idx_r;
  logic signed [15:0] offset_r;
  logic signed [15:0] volt_r;
  logic signed [15:0] temp_r;
  logic signed [15:0] cur_r;
  logic signed [15:0] avg_r;
  logic [GAIN_W-1:0] gain_r;
  logic [TC_W-1:0] tc_r;
  logic signed [19:0] tc_factor_r;
  logic signed [8:0] half_last_r;
  logic signed [15:0] hist_r [AVG_DEPTH];
  logic [AVG_SHIFT-1:0] hist_idx_r;
  gmp_acc_s acc_r;
  logic [15:0] rdata_r;

  // ----------------------------------------
  // power control
  // ----------------------------------------
  wire active = (pwr_r == GMP_ACTIVE);
  wire dq_moved = (dq_i != dq_prev_r);
  wire bus_low_cond = ctrl_r.bus_low_sleep_enable && !dq_i;
  wire uv_cond = ctrl_r.undervoltage_sleep_enable && uv_below_i && !dq_moved;
  wire qual_cond = active && (bus_low_cond || uv_cond);
  wire qual_done = qual_cond && tick(qual_cnt_r, SLEEP_CYC);
  wire dq_rise = dq_i && !dq_prev_r;
  wire dq_fall = !dq_i && dq_prev_r;

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      GMP_ACTIVE: begin
        // bus-low cause wins when both qualify: its wake needs only a high line
        if (qual_done && bus_low_cond) begin
          pwr_nxt = GMP_SLEEP_BUS;
        end else if (qual_done) begin
          pwr_nxt = GMP_SLEEP_UV;
        end
      end
      GMP_SLEEP_BUS: begin
        if (dq_i) begin
          pwr_nxt = GMP_ACTIVE;
        end
      end
      GMP_SLEEP_UV: begin
        // any edge wakes: a reset pulse from a high line counts directly
        if (dq_moved) begin
          pwr_nxt = GMP_ACTIVE;
        end
      end
      default: pwr_nxt = GMP_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_r <= GMP_ACTIVE;
      dq_prev_r <= 1'b0;
      qual_cnt_r <= '0;
    end else begin
      pwr_r <= pwr_nxt;
      dq_prev_r <= dq_i;
      // any break in the condition restarts the interval
      qual_cnt_r <= (qual_cond && !qual_done) ? qual_cnt_r + 1'b1 : '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_at_sleep_r <= 1'b0;
      presence_block_r <= 1'b0;
      overdrive_r <= 1'b0;
    end else begin
      overdrive_r <= bus_speed_select_i;
      if (qual_done) begin
        low_at_sleep_r <= !dq_i;
      end
      if (!active && dq_rise && low_at_sleep_r) begin
        presence_block_r <= 1'b1;
        low_at_sleep_r <= 1'b0;
      end else if (dq_fall) begin
        presence_block_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // timebase, gated in sleep
  // ----------------------------------------
  wire smp_tick = active && tick(smp_cnt_r, SAMPLE_CYC);
  wire vt_tick = active && tick(vt_cnt_r, VT_CYC);
  wire cur_tick = active && tick(cur_cnt_r, CUR_CYC);
  // counters freeze in sleep rather than clear, so a wake resumes the old phase

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smp_cnt_r <= '0;
      vt_cnt_r <= '0;
      cur_cnt_r <= '0;
    end else if (active) begin
      smp_cnt_r <= smp_tick ? '0 : smp_cnt_r + 1'b1;
      vt_cnt_r <= vt_tick ? '0 : vt_cnt_r + 1'b1;
      cur_cnt_r <= cur_tick ? '0 : cur_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // voltage and temperature
  // ----------------------------------------
  wire signed [15:0] volt_sat = sat16(WIDE_W'(vin_raw_i), VOLT_MIN, VOLT_MAX);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      volt_r <= '0;
      temp_r <= '0;
    end else if (vt_tick) begin
      volt_r <= volt_sat;
      temp_r <= 16'(temp_raw_i);
    end
  end

  // ----------------------------------------
  // sense resistor temperature compensation
  // ----------------------------------------
  // factor in q16: one minus trim times half degrees off the reference
  wire signed [8:0] half_now = 9'(temp_r >>> TC_HALF_SHIFT);
  wire signed [9:0] half_delta = 10'(half_now) - 10'(TC_REF_HALF);
  wire signed [19:0] tc_prod = 20'($signed({1'b0, tc_r}) * half_delta);
  wire signed [19:0] tc_factor_nxt = 20'(TC_ONE) - tc_prod;
  // a zero trim gives a factor of exactly one: compensation off

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tc_factor_r <= 20'(TC_ONE);
      half_last_r <= 9'(TC_REF_HALF);
    end else if (half_now != half_last_r) begin
      // only a crossing refreshes it, so a later trim write waits for one
      tc_factor_r <= tc_factor_nxt;
      half_last_r <= half_now;
    end
  end

  // ----------------------------------------
  // current conversion
  // ----------------------------------------
  wire ofs_slot = (conv_idx_r == '0);
  wire signed [17:0] conv_raw = 18'(sum_r >>> CONV_SHIFT);
  wire signed [18:0] conv_corr = 19'(conv_raw) - 19'(offset_r);
  wire signed [WIDE_W-1:0] gained =
    (WIDE_W'(conv_corr) * WIDE_W'($signed({1'b0, gain_r}))) >>> GAIN_FRAC;
  wire signed [WIDE_W-1:0] compensated = (gained * WIDE_W'(tc_factor_r)) >>> TC_SHIFT;
  wire signed [15:0] cur_sat = sat16(compensated, CUR_MIN, CUR_MAX);
  wire signed [15:0] cur_new = ofs_slot ? cur_r : cur_sat;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sum_r <= '0;
    end else if (cur_tick) begin
      sum_r <= smp_tick ? SUM_W'(sns_sample_i) : '0;
    end else if (smp_tick) begin
      sum_r <= sum_r + SUM_W'(sns_sample_i);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_idx_r <= '0;
      offset_r <= '0;
      cur_r <= '0;
      acc_r <= '0;
    end else begin
      acc_r.valid <= cur_tick;
      if (cur_tick) begin
        conv_idx_r <= conv_idx_r + 1'b1;
        cur_r <= cur_new;
        acc_r.value <= cur_new;
        if (ofs_slot) begin
          // held for the next 1023 conversions
          offset_r <= 16'(conv_raw);
        end
      end
    end
  end

  // ----------------------------------------
  // average current
  // ----------------------------------------
  logic signed [18:0] hist_sum;
  always_comb begin
    hist_sum = '0;
    for (int i = 0; i < AVG_DEPTH; i++) begin
      hist_sum = hist_sum + 19'(hist_r[i]);
    end
  end
  wire signed [15:0] avg_sat = sat16(WIDE_W'(hist_sum >>> AVG_SHIFT), CUR_MIN, CUR_MAX);
  // offset-slot repeats enter the history as well, as they feed accumulation
  logic avg_due_r;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hist_idx_r <= '0;
      avg_due_r <= 1'b0;
      avg_r <= '0;
      for (int i = 0; i < AVG_DEPTH; i++) begin
        hist_r[i] <= '0;
      end
    end else begin
      avg_due_r <= cur_tick && (hist_idx_r == '1);
      if (cur_tick) begin
        hist_r[hist_idx_r] <= cur_new;
        hist_idx_r <= hist_idx_r + 1'b1;
      end
      if (avg_due_r) begin
        avg_r <= avg_sat;
      end
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  // status bits are rebuilt from state every cycle, so they cannot drift from it
  wire stat_asleep = !active;
  wire stat_uv_sleep = (pwr_r == GMP_SLEEP_UV);
  wire stat_ovd = overdrive_r;
  wire stat_block = presence_block_r;
  wire [15:0] status_word =
    (16'(stat_asleep) << STAT_SLEEP_BIT) |
    (16'(stat_uv_sleep) << STAT_UV_BIT) |
    (16'(stat_ovd) << STAT_OVD_BIT) |
    (16'(stat_block) << STAT_LOWQ_BIT);

  wire [15:0] ctrl_word =
    (16'(ctrl_r.bus_low_sleep_enable) << CTRL_BLS_BIT) |
    (16'(ctrl_r.undervoltage_sleep_enable) << CTRL_UVS_BIT);
  // unmapped offsets read zero and swallow writes
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      REG_CTRL: rd_mux = ctrl_word;
      REG_STATUS: rd_mux = status_word;
      REG_VOLT: rd_mux = volt_r;
      REG_TEMP: rd_mux = temp_r;
      REG_CUR: rd_mux = cur_r;
      REG_AVG: rd_mux = avg_r;
      REG_GAIN: rd_mux = 16'(gain_r);
      REG_FGAIN: rd_mux = 16'(FACTORY_GAIN);
      REG_TC: rd_mux = 16'(tc_r);
      REG_OFFSET: rd_mux = offset_r;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= '0;
      gain_r <= GAIN_RESET;
      tc_r <= '0;
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd_i ? rd_mux : '0;
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        ctrl_r.bus_low_sleep_enable <= reg_wdata_i[CTRL_BLS_BIT];
        ctrl_r.undervoltage_sleep_enable <= reg_wdata_i[CTRL_UVS_BIT];
      end
      if (reg_wr_i && reg_addr_i == REG_GAIN) begin
        gain_r <= reg_wdata_i[GAIN_W-1:0];
      end
      if (reg_wr_i && reg_addr_i == REG_TC) begin
        tc_r <= reg_wdata_i[TC_W-1:0];
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign sample_tick_o = smp_tick;
  assign sleep_o = !active;
  assign overdrive_o = overdrive_r;
  assign presence_block_o = presence_block_r;
  assign acc_feed_o = acc_r;

endmodule : gmp_measure_power_ctrl

// *** tb/gmp_host_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// host bus master: pull-up, hold-low and reset pulse
// ----------------------------------------
module gmp_host_model #(
  parameter int PULSE_CYC = 8
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic hold_low_i,
  input wire logic reset_req_i,
  output logic dq_o
);
  int pulse_r;
  // host pull-up sets the level unless the line is pulled low
  assign dq_o = !(hold_low_i || (pulse_r != 0));
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulse_r <= 0;
    end else if (pulse_r != 0) begin
      pulse_r <= pulse_r - 1;
    end else if (reset_req_i && !hold_low_i) begin
      // a request made while the line is held low is dropped: release comes first
      pulse_r <= PULSE_CYC;
    end
  end
endmodule : gmp_host_model

// *** tb/gmp_measure_power_ctrl_monitor.sv ***
`timescale 1ns/100ps
module gmp_mpc_monitor
  import gmp_pkg::*;
#(
  parameter int SLEEP_CYC = 40,
  parameter int SAMPLE_CYC = 3
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic dq_i,
  input wire logic bus_speed_select_i,
  input wire logic sample_tick_o,
  input wire logic sleep_o,
  input wire logic overdrive_o,
  input wire logic presence_block_o,
  input wire gmp_acc_s acc_feed_o
);
  logic dq_q_r;
  int stable_r;
  // ----------------------------------------
  // run length of an unchanged data line
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dq_q_r <= 1'b0;
      stable_r <= 0;
    end else begin
      dq_q_r <= dq_i;
      stable_r <= (dq_i == dq_q_r) ? stable_r + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
    else $error("read data outside answer cycle");
  sleep_qual_time_a: assert property ($rose(sleep_o) |-> stable_r >= SLEEP_CYC - 2)
    else $error("sleep entered before qualify time");
  sleep_no_tick_a: assert property (sleep_o |-> !sample_tick_o)
    else $error("sample tick while asleep");
  sleep_no_feed_a: assert property (sleep_o && $past(sleep_o) |-> !acc_feed_o.valid)
    else $error("conversion result while asleep");
  wake_on_edge_a: assert property (sleep_o && dq_i != $past(dq_i) |=> !sleep_o)
    else $error("no wake on line change");
  sleep_holds_a: assert property (sleep_o && dq_i == $past(dq_i) && $past(dq_i) == $past(dq_i, 2) |=> sleep_o)
    else $error("sleep left with steady line");
  block_rise_a: assert property ($rose(presence_block_o) |-> $past(sleep_o) && $past(dq_i) && !$past(dq_i, 2))
    else $error("presence block without rise from low sleep");
  block_clear_a: assert property (presence_block_o && !dq_i && $past(dq_i) |=> !presence_block_o)
    else $error("presence block kept past falling edge");
  tick_period_a: assert property (sample_tick_o |-> ##SAMPLE_CYC (sample_tick_o || sleep_o || $past(sleep_o)))
    else $error("sample tick period wrong");
  tick_single_a: assert property (sample_tick_o |=> !sample_tick_o)
    else $error("sample tick longer than one cycle");
  feed_single_a: assert property (acc_feed_o.valid |=> !acc_feed_o.valid)
    else $error("feed valid longer than one cycle");
  ovd_follow_a: assert property (1'b1 |=> overdrive_o == $past(bus_speed_select_i))
    else $error("overdrive does not follow speed pin");
endmodule : gmp_mpc_monitor

bind gmp_measure_power_ctrl gmp_mpc_monitor #(.SLEEP_CYC(SLEEP_CYC), .SAMPLE_CYC(SAMPLE_CYC)) gmp_mpc_monitor_i (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .dq_i(dq_i), .bus_speed_select_i(bus_speed_select_i), .sample_tick_o(sample_tick_o), .sleep_o(sleep_o),
  .overdrive_o(overdrive_o), .presence_block_o(presence_block_o), .acc_feed_o(acc_feed_o));

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import gmp_pkg::*;
  localparam int SLP = 40;
  localparam int PCYC = 8;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rdata;
  logic dq;
  logic speed = 1'b0;
  logic uv_below = 1'b0;
  logic [15:0] vin_raw = 16'h0123;
  logic [10:0] temp_raw = 11'h7f8;
  logic [15:0] sense_resistor_input = 16'h0;
  logic tick, sleep_o, bus_speed_select, pblock;
  gmp_acc_s feed;
  logic hold_low = 1'b0;
  logic reset_req = 1'b0;
  logic [15:0] first_val, slot_val, last_val;
  logic [15:0] vt [3] = '{16'h0123, 16'h7000, 16'h8000};
  logic [15:0] ve [3] = '{16'h0123, 16'h03ff, 16'hfc00};
  int n_valid = 0;
  int cycles = 0;
  int n_mismatch = 0;
  int checks_done = 0;

  gmp_measure_power_ctrl #(.SLEEP_CYC(SLP), .VT_CYC(20), .CUR_CYC(30), .SAMPLE_CYC(3),
    .FACTORY_GAIN(11'h400)) gmp_measure_power_ctrl_i (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_en),
    .reg_rd_i(rd_en), .reg_rdata_o(rdata), .dq_i(dq), .bus_speed_select_i(speed), .uv_below_i(uv_below),
    .vin_raw_i(vin_raw), .temp_raw_i(temp_raw), .sns_sample_i(sense_resistor_input), .sample_tick_o(tick), .sleep_o(sleep_o),
    .overdrive_o(bus_speed_select), .presence_block_o(pblock), .acc_feed_o(feed));
  gmp_host_model #(.PULSE_CYC(PCYC)) gmp_host_model_i (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .hold_low_i(hold_low), .reset_req_i(reset_req), .dq_o(dq));

  initial forever #25 core_clk = ~core_clk;
  // ----------------------------------------
  // feed capture and timeout
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (feed.valid === 1'b1) begin
      if (n_valid == 0) first_val <= feed.value;
      if (n_valid == 1024) slot_val <= feed.value;
      last_val <= feed.value;
      n_valid <= n_valid + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    // the answer stands for the cycle after the strobe: sample it at that cycle's closing edge
    @(posedge core_clk);
    chk(rdata, exp);
  endtask : rd
  task automatic wait_conv(input int n);
    int t;
    t = n_valid + n;
    while (n_valid < t) @(posedge core_clk);
  endtask : wait_conv
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(REG_CTRL, 16'h0);
    rd(REG_STATUS, 16'h0000);
    rd(REG_GAIN, {5'h0, GAIN_RESET});
    wr(REG_FGAIN, 16'h0123);
    rd(REG_FGAIN, 16'h0400);
    rd(REG_TC, 16'h0);
    rd(4'hf, 16'h0);
    for (int i = 0; i < 3; i++) begin
      vin_raw <= vt[i];
      repeat (45) @(posedge core_clk);
      rd(REG_VOLT, ve[i]);
    end
    rd(REG_TEMP, 16'hfff8);
    // bus-low sleep: disabled, interrupted, then qualified
    hold_low <= 1'b1;
    repeat (SLP + 10) @(posedge core_clk);
    chk({15'h0, sleep_o}, 16'h0);
    wr(REG_CTRL, 16'h0001);
    rd(REG_CTRL, 16'h0001);
    repeat (SLP - 12) @(posedge core_clk);
    hold_low <= 1'b0;
    repeat (2) @(posedge core_clk);
    hold_low <= 1'b1;
    repeat (SLP - 5) @(posedge core_clk);
    chk({15'h0, sleep_o}, 16'h0);
    repeat (10) @(posedge core_clk);
    chk({15'h0, sleep_o}, 16'h1);
    rd(REG_STATUS, 16'h0001);
    vin_raw <= 16'h0050;
    repeat (45) @(posedge core_clk);
    rd(REG_VOLT, 16'hfc00);
    hold_low <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({14'h0, sleep_o, pblock}, 16'h1);
    reset_req <= 1'b1;
    @(posedge core_clk);
    reset_req <= 1'b0;
    repeat (PCYC + 3) @(posedge core_clk);
    chk({15'h0, pblock}, 16'h0);
    // undervoltage sleep entered with the line high
    wr(REG_CTRL, 16'h0002);
    uv_below <= 1'b1;
    repeat (SLP + 10) @(posedge core_clk);
    rd(REG_STATUS, 16'h0003);
    reset_req <= 1'b1;
    @(posedge core_clk);
    reset_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({14'h0, sleep_o, pblock}, 16'h0);
    uv_below <= 1'b0;
    wr(REG_CTRL, 16'h0000);
    speed <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({15'h0, bus_speed_select}, 16'h1);
    rd(REG_STATUS, 16'h0004);
    speed <= 1'b0;
    // current path; expectations floor-shift robust to one sample of phase
    chk(first_val, 16'h0);
    sense_resistor_input <= 16'h4000;
    wait_conv(2);
    rd(REG_CUR, 16'h0002);
    chk(last_val, 16'h0002);
    wr(REG_GAIN, 16'h0200);
    wait_conv(2);
    rd(REG_CUR, 16'h0001);
    sense_resistor_input <= 16'hc000;
    wait_conv(2);
    rd(REG_CUR, 16'hfffe);
    wr(REG_GAIN, 16'h0400);
    wait_conv(17);
    rd(REG_CUR, 16'hfffd);
    rd(REG_AVG, 16'hfffd);
    // a trim write alone must not move the factor; the next half-degree crossing does
    wr(REG_TC, 16'h0080);
    rd(REG_TC, 16'h0080);
    wait_conv(2);
    rd(REG_CUR, 16'hfffd);
    temp_raw <= 11'h7f0;
    wait_conv(2);
    rd(REG_TEMP, 16'hfff0);
    rd(REG_CUR, 16'hfffc);
    while (n_valid < 1026) @(posedge core_clk);
    chk(slot_val, 16'hfffc);
    rd(REG_CUR, 16'h0000);
    final_report();
  end
endmodule : tb_top
